// File: mcis_regs.vh
// Constants for the instruction subset unit: opcodes, register map, resets.
// Included by bare name; holds definitions only.
`ifndef MCIS_REGS_VH
`define MCIS_REGS_VH

// Instruction word
`define MCIS_IW                10
`define MCIS_OP_INDEX_DEC      10'h017
`define MCIS_OP_IRQ_DISABLE    10'h010
`define MCIS_OP_IRQ_ENABLE     10'h014
`define MCIS_OP_RC_CLK_SEL     10'h29B
`define MCIS_OP_WDT_STOP_ARM   10'h29C
`define MCIS_OP_PWR_OFF_ARM    10'h05B
`define MCIS_OP_PORT0_IN       10'h260
`define MCIS_OP_PWR_OFF        10'h002

// Index wrap value that causes a skip
`define MCIS_INDEX_WRAP        4'hF

// Delay of the interrupt enable change, in machine cycles
`define MCIS_IRQ_DELAY_MC      1

// Register byte addresses
`define MCIS_ADDR_STATUS       8'h00
`define MCIS_ADDR_INDEX        8'h04
`define MCIS_ADDR_ACC          8'h08
`define MCIS_ADDR_CARRY        8'h0C

// Status field positions
`define MCIS_ST_IRQ_FLAG       0
`define MCIS_ST_IRQ_LIVE       1
`define MCIS_ST_RC_SEL         2
`define MCIS_ST_WDT_ARM        3
`define MCIS_ST_POF_ARM        4
`define MCIS_ST_SKIP           5
`define MCIS_ST_POF_DONE       6

// Reset values
`define MCIS_RST_NIBBLE        4'h0
`define MCIS_RST_BYTE          8'h00

`endif

// File: mcis_decode.v
// One-hot decoder for the instruction subset.
// Assumes the opcode word is stable while its valid is high.
`timescale 1ns/1ns
`default_nettype none
`include "mcis_regs.vh"

module mcis_decode (
	// Instruction in
	input  wire [`MCIS_IW-1:0] i_instr,
	input  wire                i_valid,
	// One-hot hits
	output reg                 o_index_decrement_op,
	output reg                 o_irq_disable_op,
	output reg                 o_irq_enable_op,
	output reg                 o_rc_clock_select_op,
	output reg                 o_watchdog_stop_arm_op,
	output reg                 o_power_off_arm_op,
	output reg                 o_power_off_op,
	output reg                 o_port_zero_in_op
);

	always @* begin
		o_index_decrement_op   = 1'b0;
		o_irq_disable_op       = 1'b0;
		o_irq_enable_op        = 1'b0;
		o_rc_clock_select_op   = 1'b0;
		o_watchdog_stop_arm_op = 1'b0;
		o_power_off_arm_op     = 1'b0;
		o_power_off_op         = 1'b0;
		o_port_zero_in_op      = 1'b0;
		if (i_valid) begin
			case (i_instr)
				`MCIS_OP_INDEX_DEC:    o_index_decrement_op   = 1'b1;
				`MCIS_OP_IRQ_DISABLE:  o_irq_disable_op       = 1'b1;
				`MCIS_OP_IRQ_ENABLE:   o_irq_enable_op        = 1'b1;
				`MCIS_OP_RC_CLK_SEL:   o_rc_clock_select_op   = 1'b1;
				`MCIS_OP_WDT_STOP_ARM: o_watchdog_stop_arm_op = 1'b1;
				`MCIS_OP_PWR_OFF_ARM:  o_power_off_arm_op     = 1'b1;
				`MCIS_OP_PWR_OFF:      o_power_off_op         = 1'b1;
				`MCIS_OP_PORT0_IN:     o_port_zero_in_op      = 1'b1;
				default: begin
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// File: mcis_core.v
// Execution unit for a subset of single-word control instructions.
// Assumes one i_instr_valid pulse per machine cycle, synchronous inputs,
// and a register master that never issues read and write together.
//
// Contract
// - Index decrement subtracts one from the 4-bit index and stores it back.
// - If the decremented index is fifteen, the next instruction is skipped.
// - Interrupt disable clears the enable flag; takes effect one machine cycle later.
// - Interrupt enable sets the enable flag; takes effect one machine cycle later.
// - RC clock select chooses the internal RC oscillator as main clock.
// - Watchdog stop arm enables the stop function, does not stop the timer.
// - Power-off arm makes a later power-off effective; unarmed power-off is ignored.
// - Port zero input copies port zero into the accumulator, carry unchanged.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "mcis_regs.vh"

module mcis_core #(
	parameter NW = 4,
	parameter DW = 8,
	parameter AW = 8
) (
	// Clock and reset
	input  wire          i_clk_sys,
	input  wire          i_rst_n,
	// Instruction stream
	input  wire [9:0]    i_instr,
	input  wire          i_instr_valid,
	// Input port zero
	input  wire [NW-1:0] i_input_port_zero,
	// Register port
	input  wire [AW-1:0] i_addr,
	input  wire [DW-1:0] i_wdata,
	input  wire          i_wr,
	input  wire          i_rd,
	output reg  [DW-1:0] o_rdata,
	// Core state
	output reg  [NW-1:0] o_index,
	output reg  [NW-1:0] o_acc,
	output reg           o_carry,
	output reg           o_skip_pending,
	output reg           o_instr_done,
	// System controls
	output reg           o_global_irq_enable_flag,
	output reg           o_irq_live,
	output reg           o_rc_clock_sel,
	output reg           o_watchdog_stop_en,
	output reg           o_power_off_armed,
	output reg           o_power_off
);

	// Decoder hits, already gated by a pending skip
	wire hit_dec;
	wire hit_di;
	wire hit_ei;
	wire hit_rc;
	wire hit_wdt;
	wire hit_pofarm;
	wire hit_pof;
	wire hit_p0;
	wire exec;

	// Next-state terms
	reg  [NW-1:0] next_index;
	reg  [NW-1:0] next_acc;
	reg           next_carry;
	reg           next_skip;
	reg           next_flag;
	reg           next_live;
	reg           next_pof_armed;
	reg           next_pof;
	reg           pof_done;
	reg  [DW-1:0] status;
	reg  [DW-1:0] next_rdata;
	wire          wr_index;
	wire          wr_acc;
	wire          wr_carry;

	// A skipped word is fetched but not executed
	assign exec = i_instr_valid & ~o_skip_pending;

	// Status has no write term: software cannot fake a flag
	assign wr_index = i_wr & (i_addr == `MCIS_ADDR_INDEX);
	assign wr_acc   = i_wr & (i_addr == `MCIS_ADDR_ACC);
	assign wr_carry = i_wr & (i_addr == `MCIS_ADDR_CARRY);

	mcis_decode u_decode (
		.i_instr                (i_instr),
		.i_valid                (exec),
		.o_index_decrement_op   (hit_dec),
		.o_irq_disable_op       (hit_di),
		.o_irq_enable_op        (hit_ei),
		.o_rc_clock_select_op   (hit_rc),
		.o_watchdog_stop_arm_op (hit_wdt),
		.o_power_off_arm_op     (hit_pofarm),
		.o_power_off_op         (hit_pof),
		.o_port_zero_in_op      (hit_p0)
	);

	// Next state; instruction effects win over register writes
	always @* begin
		next_index     = o_index;
		next_acc       = o_acc;
		next_carry     = o_carry;
		next_skip      = o_skip_pending;
		next_flag      = o_global_irq_enable_flag;
		next_live      = o_irq_live;
		next_pof_armed = o_power_off_armed;
		next_pof       = 1'b0;

		if (wr_index)
			next_index = i_wdata[NW-1:0];
		if (wr_acc)
			next_acc = i_wdata[NW-1:0];
		if (wr_carry)
			next_carry = i_wdata[0];

		// Instruction effects below override a same-cycle write
		if (i_instr_valid) begin
			// Live enable trails the flag by one machine cycle
			next_live = o_global_irq_enable_flag;
			if (o_skip_pending)
				next_skip = 1'b0;
		end
		if (hit_dec) begin
			next_index = o_index - {{(NW-1){1'b0}}, 1'b1};
			next_skip  = (next_index == `MCIS_INDEX_WRAP);
		end
		if (hit_di)
			next_flag = 1'b0;
		if (hit_ei)
			next_flag = 1'b1;
		if (hit_p0)
			next_acc = i_input_port_zero;
		if (hit_pofarm)
			next_pof_armed = 1'b1;
		if (hit_pof && o_power_off_armed) begin
			// Arm is consumed so a second power-off needs a new arm
			next_pof       = 1'b1;
			next_pof_armed = 1'b0;
		end
	end

	// Carry is never touched by an instruction of this set
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_index                  <= `MCIS_RST_NIBBLE;
			o_acc                    <= `MCIS_RST_NIBBLE;
			o_carry                  <= 1'b0;
			o_skip_pending           <= 1'b0;
			o_global_irq_enable_flag <= 1'b0;
			o_irq_live               <= 1'b0;
			o_power_off_armed        <= 1'b0;
			o_power_off              <= 1'b0;
			o_instr_done             <= 1'b0;
		end else begin
			o_index                  <= next_index;
			o_acc                    <= next_acc;
			o_carry                  <= next_carry;
			o_skip_pending           <= next_skip;
			o_global_irq_enable_flag <= next_flag;
			o_irq_live               <= next_live;
			o_power_off_armed        <= next_pof_armed;
			o_power_off              <= next_pof;
			o_instr_done             <= exec;
		end
	end

	// Clock select and watchdog arm are one-way until reset
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_rc_clock_sel     <= 1'b0;
			o_watchdog_stop_en <= 1'b0;
			pof_done           <= 1'b0;
		end else begin
			if (hit_rc)
				o_rc_clock_sel <= 1'b1;
			// Only permits a later stop; the timer itself keeps running
			if (hit_wdt)
				o_watchdog_stop_en <= 1'b1;
			if (next_pof)
				pof_done <= 1'b1;
		end
	end

	always @* begin
		status                       = `MCIS_RST_BYTE;
		status[`MCIS_ST_IRQ_FLAG]    = o_global_irq_enable_flag;
		status[`MCIS_ST_IRQ_LIVE]    = o_irq_live;
		status[`MCIS_ST_RC_SEL]      = o_rc_clock_sel;
		status[`MCIS_ST_WDT_ARM]     = o_watchdog_stop_en;
		status[`MCIS_ST_POF_ARM]     = o_power_off_armed;
		status[`MCIS_ST_SKIP]        = o_skip_pending;
		status[`MCIS_ST_POF_DONE]    = pof_done;
	end

	// Read mux; unmapped addresses and idle cycles give zero
	always @* begin
		next_rdata = `MCIS_RST_BYTE;
		if (i_rd) begin
			if (i_addr == `MCIS_ADDR_STATUS)
				next_rdata = status;
			else if (i_addr == `MCIS_ADDR_INDEX)
				next_rdata = {{(DW-NW){1'b0}}, o_index};
			else if (i_addr == `MCIS_ADDR_ACC)
				next_rdata = {{(DW-NW){1'b0}}, o_acc};
			else if (i_addr == `MCIS_ADDR_CARRY)
				next_rdata = {{(DW-1){1'b0}}, o_carry};
		end
	end

	// Read data valid only in the cycle after the strobe
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_rdata <= `MCIS_RST_BYTE;
		end else begin
			o_rdata <= next_rdata;
		end
	end

endmodule
`default_nettype wire

// File: mcis_monitor.sv
// Concurrent checks on the instruction subset core ports.
// Bound onto every core instance; sees only the core's ports.
`timescale 1ns/1ns
`default_nettype none
`include "mcis_regs.vh"
module mcis_monitor (
	input wire logic       i_clk_sys, i_rst_n, i_instr_valid, i_wr,
	input wire logic [9:0] i_instr,
	input wire logic [3:0] i_input_port_zero, o_index, o_acc,
	input wire logic       o_carry, o_skip_pending, o_instr_done, o_power_off,
	input wire logic       o_global_irq_enable_flag, o_irq_live, o_rc_clock_sel,
	input wire logic       o_watchdog_stop_en, o_power_off_armed
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// A skipped word is consumed but never executed
	wire tk = i_instr_valid & ~o_skip_pending;
	property p_dec; tk && i_instr == `MCIS_OP_INDEX_DEC |=> o_index == $past(o_index) - 4'h1
		&& o_skip_pending == (o_index == `MCIS_INDEX_WRAP); endproperty
	a_dec: assert property (p_dec) else $error("index decrement wrong");
	property p_skip; i_instr_valid && o_skip_pending |=> !o_skip_pending && !o_instr_done; endproperty
	a_skip: assert property (p_skip) else $error("skip not applied");
	property p_di; tk && i_instr == `MCIS_OP_IRQ_DISABLE |=> !o_global_irq_enable_flag; endproperty
	a_di: assert property (p_di) else $error("enable flag not cleared");
	property p_ei; tk && i_instr == `MCIS_OP_IRQ_ENABLE |=> o_global_irq_enable_flag; endproperty
	a_ei: assert property (p_ei) else $error("enable flag not set");
	property p_live; tk |=> o_irq_live == $past(o_global_irq_enable_flag); endproperty
	a_live: assert property (p_live) else $error("live enable lag wrong");
	property p_rc; tk && i_instr == `MCIS_OP_RC_CLK_SEL |=> o_rc_clock_sel; endproperty
	a_rc: assert property (p_rc) else $error("rc clock not selected");
	property p_wdt; tk && i_instr == `MCIS_OP_WDT_STOP_ARM |=> o_watchdog_stop_en && !o_power_off;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog stop not armed");
	property p_pof; tk && i_instr == `MCIS_OP_PWR_OFF |=> o_power_off == $past(o_power_off_armed)
		##1 !o_power_off; endproperty
	a_pof: assert property (p_pof) else $error("power off gating wrong");
	property p_p0; tk && i_instr == `MCIS_OP_PORT0_IN |=> o_acc == $past(i_input_port_zero);
	endproperty
	a_p0: assert property (p_p0) else $error("port zero not loaded");
	property p_cy; !i_wr |=> $stable(o_carry) ##0 (o_instr_done == $past(tk)); endproperty
	a_cy: assert property (p_cy) else $error("carry or done wrong");
endmodule
bind mcis_core mcis_monitor u_mon (
	.i_clk_sys                (i_clk_sys),
	.i_rst_n                  (i_rst_n),
	.i_instr_valid            (i_instr_valid),
	.i_wr                     (i_wr),
	.i_instr                  (i_instr),
	.i_input_port_zero        (i_input_port_zero),
	.o_index                  (o_index),
	.o_acc                    (o_acc),
	.o_carry                  (o_carry),
	.o_skip_pending           (o_skip_pending),
	.o_instr_done             (o_instr_done),
	.o_power_off              (o_power_off),
	.o_global_irq_enable_flag (o_global_irq_enable_flag),
	.o_irq_live               (o_irq_live),
	.o_rc_clock_sel           (o_rc_clock_sel),
	.o_watchdog_stop_en       (o_watchdog_stop_en),
	.o_power_off_armed        (o_power_off_armed)
);
`default_nettype wire

// File: tb.sv
// Self-checking bench for the instruction subset core.
// Drives every core input itself; read data are checked from a queue.
`timescale 1ns/1ns
`default_nettype none
`include "mcis_regs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
	logic       i_clk_sys, i_rst_n, i_instr_valid, i_wr, i_rd, rd_seen;
	logic [9:0] i_instr;
	logic [3:0] i_input_port_zero, o_index, o_acc, acc_e;
	logic [7:0] i_addr, i_wdata, o_rdata, v8, exp_q[$];
	logic       o_carry, o_skip_pending, o_instr_done, o_global_irq_enable_flag;
	logic       o_irq_live, o_rc_clock_sel, o_watchdog_stop_en, o_power_off_armed, o_power_off;
	int         mismatches, check_count;
	mcis_core uut (
		.i_clk_sys                (i_clk_sys),
		.i_rst_n                  (i_rst_n),
		.i_instr                  (i_instr),
		.i_instr_valid            (i_instr_valid),
		.i_input_port_zero        (i_input_port_zero),
		.i_addr                   (i_addr),
		.i_wdata                  (i_wdata),
		.i_wr                     (i_wr),
		.i_rd                     (i_rd),
		.o_rdata                  (o_rdata),
		.o_index                  (o_index),
		.o_acc                    (o_acc),
		.o_carry                  (o_carry),
		.o_skip_pending           (o_skip_pending),
		.o_instr_done             (o_instr_done),
		.o_global_irq_enable_flag (o_global_irq_enable_flag),
		.o_irq_live               (o_irq_live),
		.o_rc_clock_sel           (o_rc_clock_sel),
		.o_watchdog_stop_en       (o_watchdog_stop_en),
		.o_power_off_armed        (o_power_off_armed),
		.o_power_off              (o_power_off)
	);
	task automatic ex(input logic [9:0] w);
		@(posedge i_clk_sys);
		i_instr <= w;
		i_instr_valid <= 1'b1;
		@(posedge i_clk_sys);
		i_instr_valid <= 1'b0;
		#1;
	endtask
	task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic wr);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= wr;
		i_rd <= !wr;
		if (!wr) exp_q.push_back(d);
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge i_clk_sys) rd_seen <= i_rd;
	always @(negedge i_clk_sys) begin
		if (rd_seen === 1'b1) begin
			v8 = exp_q.pop_front();
			`CHK(o_rdata, v8)
		end
	end
	initial begin
		i_clk_sys = 1'b0;
		forever #4 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		#100000;
		mismatches++;
		results();
	end
	initial begin
		{i_rst_n, i_instr_valid, i_wr, i_rd} = '0;
		{i_instr, i_addr, i_wdata, i_input_port_zero, acc_e} = '0;
		void'($urandom(24));
		repeat (8) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		// Status is read-only, so this write must vanish
		bus(`MCIS_ADDR_STATUS, 8'hFF, 1'b1);
		bus(`MCIS_ADDR_STATUS, 8'h00, 1'b0);
		bus(`MCIS_ADDR_CARRY, 8'h01, 1'b1);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			bus(`MCIS_ADDR_INDEX, 8'(i), 1'b1);
			ex(`MCIS_OP_INDEX_DEC);
			`CHK(o_index, 4'(i - 1))
			`CHK(o_skip_pending, i == 0)
			@(posedge i_clk_sys);
			i_input_port_zero <= 4'($urandom);
			ex(`MCIS_OP_PORT0_IN);
			if (i != 0) acc_e = i_input_port_zero;
			`CHK(o_acc, acc_e)
			`CHK(o_instr_done, i != 0)
			`CHK(o_carry, 1'b1)
		end
		bus(`MCIS_ADDR_ACC, {4'h0, acc_e}, 1'b0);
		bus(`MCIS_ADDR_INDEX, 8'h0E, 1'b0);
		$display("test decrement done");
		ex(`MCIS_OP_IRQ_ENABLE);
		`CHK({o_global_irq_enable_flag, o_irq_live}, 2'b10)
		ex(10'h000);
		`CHK(o_irq_live, 1'b1)
		ex(`MCIS_OP_IRQ_DISABLE);
		`CHK({o_global_irq_enable_flag, o_irq_live}, 2'b01)
		ex(10'h000);
		`CHK(o_irq_live, 1'b0)
		ex(`MCIS_OP_RC_CLK_SEL);
		`CHK({o_rc_clock_sel, o_watchdog_stop_en}, 2'b10)
		ex(`MCIS_OP_WDT_STOP_ARM);
		`CHK({o_watchdog_stop_en, o_power_off}, 2'b10)
		ex(`MCIS_OP_PWR_OFF);
		`CHK(o_power_off, 1'b0)
		ex(`MCIS_OP_PWR_OFF_ARM);
		`CHK(o_power_off_armed, 1'b1)
		ex(`MCIS_OP_PWR_OFF);
		`CHK({o_power_off, o_power_off_armed}, 2'b10)
		bus(`MCIS_ADDR_STATUS, 8'h4C, 1'b0);
		bus(8'h10, 8'h00, 1'b0);
		repeat (2) @(posedge i_clk_sys);
		$display("test controls done");
		results();
	end
endmodule
`default_nettype wire
